// ### lsc_far_tx.sv
`timescale 1ns/1ps
`default_nettype none
module lsc_far_tx
    import lsc_pkg::*;
(
    input wire logic bit_clock,
    input wire logic align,
    input wire logic corrupt,
    input wire logic [WORD_BITS-1:0] word,
    output logic serial,
    output logic frame_tick
);
    logic [FRAME_BITS-1:0] frame = '0;
    int pos = 0;

    initial
    begin
        serial = 1'b0;
        frame_tick = 1'b0;
    end

    // The line changes on the falling edge, so a receiver that samples on the rising edge
    // always sees a settled bit. A corrupted frame carries a wrong start clock bit.
    always @(negedge bit_clock)
    begin
        if (pos == 0)
        begin
            frame = {STOP_BIT, (align ? ALIGN_WORD : word), START_BIT ^ corrupt};
        end
        serial <= frame[pos];
        frame_tick <= (pos == 0);
        pos = (pos == FRAME_BITS - 1) ? 0 : pos + 1;
    end
endmodule
`default_nettype wire

// ### lsc_pkg.sv
package lsc_pkg;
    localparam int WORD_BITS = 10;
    localparam int FRAME_BITS = 12;
    localparam int START_POS = 0;
    localparam int STOP_POS = FRAME_BITS - 1;
    localparam logic START_BIT = 1'b1;
    localparam logic STOP_BIT = 1'b0;
    localparam logic [3:0] LAST_POS = 4'(FRAME_BITS - 1);
    localparam logic [3:0] RCLK_HIGH_BITS = 4'(FRAME_BITS / 2);
    localparam logic [WORD_BITS-1:0] ALIGN_WORD = 10'h01F;
    localparam int LOCK_FRAMES = 4;
    localparam int LOSS_FRAMES = 4;
    localparam logic [2:0] LOCK_LAST = 3'(LOCK_FRAMES - 1);
    localparam logic [2:0] LOSS_LAST = 3'(LOSS_FRAMES - 1);
    localparam int TX_INIT_CYCLES = 510;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_IRQ_STAT = 5'h08;
    localparam logic [4:0] REG_IRQ_MASK = 5'h0C;
    localparam logic [4:0] REG_RX_WORD = 5'h10;
    localparam int CTRL_ALIGN_BIT = 0;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_TXRDY_BIT = 1;
    localparam int STAT_BAD_LSB = 2;
    localparam logic CTRL_RESET = 1'b0;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam int PIN_COUNT = 7;

    typedef struct packed {
        logic tx_ready;
        logic lock_lost;
        logic lock_gained;
    } lsc_irq_t;

    typedef enum logic [1:0] {RX_SLEEP, RX_SEARCH, RX_CHECK, RX_LOCKED} lsc_rx_state_t;
    typedef enum logic [1:0] {TX_SLEEP, TX_INIT, TX_RUN} lsc_tx_state_t;

    function automatic logic frame_ok(input logic [FRAME_BITS-1:0] f);
        frame_ok = (f[START_POS] == START_BIT) && (f[STOP_POS] == STOP_BIT);
    endfunction
endpackage

// ### lsc_serdes.sv
`timescale 1ns/1ps
`default_nettype none
module lsc_serdes
    import lsc_pkg::*;
#(
    parameter int INIT_CYCLES = TX_INIT_CYCLES
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic transmit_clock,
    input wire logic [WORD_BITS-1:0] tx_word,
    input wire logic align_request_a,
    input wire logic align_request_b,
    input wire logic sleep_n,
    input wire logic out_enable,
    output logic ser_out,
    input wire logic rx_serial,
    input wire logic receiver_reference_clock,
    output logic lock_n,
    output logic [WORD_BITS-1:0] parallel_out_word,
    output logic parallel_out_oe,
    output logic rclk_out,
    output logic rclk_oe
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] pins_s;
    logic [PIN_COUNT-1:0] pins_rise;
    logic [WORD_BITS-1:0] tx_word_s;
    logic transmit_clock_ev;
    logic rbit_ev;
    logic rx_s;
    logic align_a_s;
    logic align_b_s;
    logic sleep_s;
    logic oe_s;

    lsc_sync #(.W(PIN_COUNT)) u_pin_sync (
        .mclk(mclk),
        .resetn(resetn),
        .d({transmit_clock, receiver_reference_clock, rx_serial, align_request_a,
            align_request_b, sleep_n, out_enable}),
        .q(pins_s),
        .rise(pins_rise)
    );

    // The word is only sampled at frame start, so it must be held steady around it.
    lsc_sync #(.W(WORD_BITS)) u_word_sync (
        .mclk(mclk),
        .resetn(resetn),
        .d(tx_word),
        .q(tx_word_s),
        .rise()
    );

    assign transmit_clock_ev = pins_rise[6];
    assign rbit_ev = pins_rise[5];
    assign rx_s = pins_s[4];
    assign align_a_s = pins_s[3];
    assign align_b_s = pins_s[2];
    assign sleep_s = pins_s[1];
    assign oe_s = pins_s[0];

    // ------------------------------------------------------------
    // Serializer
    // ------------------------------------------------------------
    logic ctrl_align;
    logic tx_ready;
    logic tx_init_done;

    lsc_tx #(.INIT_CYCLES(INIT_CYCLES)) u_tx (
        .mclk(mclk),
        .resetn(resetn),
        .transmit_clock_rise(transmit_clock_ev),
        .sleep_n(sleep_s),
        .align(align_a_s || align_b_s || ctrl_align),
        .word(tx_word_s),
        .ser_out(ser_out),
        .ready(tx_ready),
        .init_done(tx_init_done)
    );

    // ------------------------------------------------------------
    // Deserializer
    // ------------------------------------------------------------
    lsc_rx_state_t rx_state, next_rx_state;
    logic [FRAME_BITS-1:0] sh, next_sh, frame_sh;
    logic [WORD_BITS-1:0] frame_data;
    logic [3:0] pos, next_pos;
    logic [2:0] good_cnt, next_good_cnt;
    logic [2:0] bad_cnt, next_bad_cnt;
    logic [WORD_BITS-1:0] next_word;
    logic next_lock_n;
    logic next_par_oe;
    logic next_rclk;
    logic boundary;
    logic rx_sleep;
    logic gained_ev;
    logic lost_ev;

    assign frame_sh = {rx_s, sh[FRAME_BITS-1:1]};
    assign frame_data = frame_sh[WORD_BITS:1];
    assign boundary = (pos == LAST_POS);
    assign rx_sleep = !sleep_s && !oe_s;

    always_comb
    begin
        next_rx_state = rx_state;
        next_sh = sh;
        next_pos = pos;
        next_good_cnt = good_cnt;
        next_bad_cnt = bad_cnt;
        next_word = parallel_out_word;
        gained_ev = 1'b0;
        lost_ev = 1'b0;
        if (rx_sleep)
        begin
            next_rx_state = RX_SLEEP;
            next_pos = '0;
            next_good_cnt = '0;
            next_bad_cnt = '0;
        end
        else if (rbit_ev)
        begin
            next_sh = frame_sh;
            next_pos = boundary ? 4'h0 : 4'(pos + 4'h1);
            case (rx_state)
                RX_SLEEP:
                begin
                    next_rx_state = RX_SEARCH;
                    next_pos = '0;
                end
                RX_SEARCH:
                begin
                    // Words with a 0 below a 1 can give a false clock-bit position; alignment frames have none.
                    if (frame_ok(frame_sh))
                    begin
                        next_rx_state = RX_CHECK;
                        next_pos = '0;
                        next_good_cnt = 3'h1;
                    end
                end
                RX_CHECK:
                begin
                    if (boundary)
                    begin
                        if (!frame_ok(frame_sh))
                        begin
                            next_rx_state = RX_SEARCH;
                        end
                        else if (good_cnt == LOCK_LAST)
                        begin
                            next_rx_state = RX_LOCKED;
                            next_bad_cnt = '0;
                            next_word = frame_data;
                            gained_ev = 1'b1;
                        end
                        else
                        begin
                            next_good_cnt = 3'(good_cnt + 3'h1);
                        end
                    end
                end
                RX_LOCKED:
                begin
                    if (boundary)
                    begin
                        // Words keep flowing during a loss; the last few may be corrupt.
                        next_word = frame_data;
                        if (frame_ok(frame_sh))
                        begin
                            next_bad_cnt = '0;
                        end
                        else if (bad_cnt == LOSS_LAST)
                        begin
                            next_rx_state = RX_SEARCH;
                            next_bad_cnt = '0;
                            lost_ev = 1'b1;
                        end
                        else
                        begin
                            next_bad_cnt = 3'(bad_cnt + 3'h1);
                        end
                    end
                end
                default:
                begin
                    next_rx_state = RX_SEARCH;
                end
            endcase
        end
        next_lock_n = (next_rx_state != RX_LOCKED);
        next_par_oe = !next_lock_n && oe_s;
        next_rclk = !next_lock_n && (next_pos < RCLK_HIGH_BITS);
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_state <= RX_SLEEP;
            sh <= '0;
            pos <= '0;
            good_cnt <= '0;
            bad_cnt <= '0;
            parallel_out_word <= '0;
            lock_n <= 1'b1;
            parallel_out_oe <= 1'b0;
            rclk_out <= 1'b0;
            rclk_oe <= 1'b0;
        end
        else
        begin
            rx_state <= next_rx_state;
            sh <= next_sh;
            pos <= next_pos;
            good_cnt <= next_good_cnt;
            bad_cnt <= next_bad_cnt;
            parallel_out_word <= next_word;
            lock_n <= next_lock_n;
            parallel_out_oe <= next_par_oe;
            rclk_out <= next_rclk;
            rclk_oe <= next_par_oe;
        end
    end

    // ------------------------------------------------------------
    // Register slave and interrupts
    // ------------------------------------------------------------
    logic ack, next_ack;
    logic take;
    logic next_ctrl_align;
    lsc_irq_t irq_stat, next_irq_stat;
    lsc_irq_t irq_mask, next_irq_mask;
    lsc_irq_t irq_ev;
    logic [31:0] next_readdata;

    // One wait cycle lets read data come from a flop without a long read path.
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign take = (avs_read || avs_write) && ack;
    assign irq_ev = '{tx_ready: tx_init_done, lock_lost: lost_ev, lock_gained: gained_ev};

    always_comb
    begin
        next_ack = (avs_read || avs_write) && !ack;
        next_ctrl_align = ctrl_align;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_readdata = avs_readdata;
        if (take && avs_write)
        begin
            case (avs_address)
                REG_CTRL: next_ctrl_align = avs_writedata[CTRL_ALIGN_BIT];
                REG_IRQ_STAT: next_irq_stat = irq_stat & ~lsc_irq_t'(avs_writedata[2:0]);
                REG_IRQ_MASK: next_irq_mask = lsc_irq_t'(avs_writedata[2:0]);
                default: next_ctrl_align = ctrl_align;
            endcase
        end
        // A new event in the clearing cycle survives the clear.
        next_irq_stat = next_irq_stat | irq_ev;
        if (avs_read && !ack)
        begin
            next_readdata = '0;
            case (avs_address)
                REG_CTRL: next_readdata[CTRL_ALIGN_BIT] = ctrl_align;
                REG_STATUS:
                begin
                    next_readdata[STAT_LOCK_BIT] = !lock_n;
                    next_readdata[STAT_TXRDY_BIT] = tx_ready;
                    next_readdata[STAT_BAD_LSB +: 3] = bad_cnt;
                end
                REG_IRQ_STAT: next_readdata[2:0] = irq_stat;
                REG_IRQ_MASK: next_readdata[2:0] = irq_mask;
                REG_RX_WORD: next_readdata[WORD_BITS-1:0] = parallel_out_word;
                default: next_readdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack <= 1'b0;
            ctrl_align <= CTRL_RESET;
            irq_stat <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            avs_readdata <= '0;
        end
        else
        begin
            ack <= next_ack;
            ctrl_align <= next_ctrl_align;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            avs_readdata <= next_readdata;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_bad_last_frame;
        !rx_sleep && rbit_ev && rx_state == RX_LOCKED && boundary && !frame_ok(frame_sh);
    endsequence

    sequence s_good_boundary;
        !rx_sleep && rbit_ev && rx_state == RX_LOCKED && boundary;
    endsequence

    chk_loss_after_four: assert property (lost_ev |-> bad_cnt == LOSS_LAST)
        else $error("lock lost too early");
    chk_lost_lock_high: assert property (s_bad_last_frame ##0 bad_cnt == LOSS_LAST
        |=> lock_n && rx_state == RX_SEARCH)
        else $error("lock status not raised on loss");
    chk_lock_low_tie: assert property ($fell(lock_n) |-> rx_state == RX_LOCKED
        && $past(rx_state) == RX_CHECK)
        else $error("lock status fell without lock");
    chk_tristate_unlocked: assert property (lock_n |-> !parallel_out_oe && !rclk_oe)
        else $error("outputs driven while unlocked");
    chk_oe_gates_out: assert property (!oe_s |=> !parallel_out_oe && !rclk_oe)
        else $error("outputs driven with enable low");
    chk_sleep_stops: assert property (rx_sleep |=> rx_state == RX_SLEEP && lock_n)
        else $error("sleep did not stop receive loop");
    chk_word_delivered: assert property (s_good_boundary
        |=> parallel_out_word == $past(frame_data))
        else $error("received word not delivered");
endmodule
`default_nettype wire

// ### lsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lsc_sync
    import lsc_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] rise
);
    logic [W-1:0] meta;
    logic [W-1:0] q_d;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;
    logic [W-1:0] next_q_d;

    always_comb
    begin
        next_meta = d;
        next_q = meta;
        next_q_d = q;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta <= '0;
            q <= '0;
            q_d <= '0;
        end
        else
        begin
            meta <= next_meta;
            q <= next_q;
            q_d <= next_q_d;
        end
    end

    assign rise = q & ~q_d;
endmodule
`default_nettype wire

// ### lsc_tx.sv
`timescale 1ns/1ps
`default_nettype none
module lsc_tx
    import lsc_pkg::*;
#(
    parameter int INIT_CYCLES = TX_INIT_CYCLES
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic transmit_clock_rise,
    input wire logic sleep_n,
    input wire logic align,
    input wire logic [WORD_BITS-1:0] word,
    output logic ser_out,
    output logic ready,
    output logic init_done
);
    lsc_tx_state_t state, next_state;
    logic [9:0] cnt, next_cnt;
    logic [3:0] pos, next_pos;
    logic [FRAME_BITS-1:0] cur, next_cur;
    logic next_ser;
    logic load;
    logic send_align;

    // Alignment frames also fill the initialization period so the far end can train early.
    assign send_align = align || (state != TX_RUN);

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_pos = pos;
        next_cur = cur;
        next_ser = ser_out;
        load = 1'b0;
        init_done = 1'b0;
        if (!sleep_n)
        begin
            next_state = TX_SLEEP;
            next_cnt = '0;
            next_pos = '0;
            next_ser = STOP_BIT;
        end
        else if (transmit_clock_rise)
        begin
            if (state == TX_SLEEP)
            begin
                next_state = TX_INIT;
                next_cnt = '0;
            end
            else
            begin
                next_pos = (pos == LAST_POS) ? 4'h0 : 4'(pos + 4'h1);
                if (pos == 4'h0)
                begin
                    load = 1'b1;
                    next_cur = {STOP_BIT, (send_align ? ALIGN_WORD : word), START_BIT};
                    next_ser = START_BIT;
                end
                else
                begin
                    next_ser = cur[pos];
                end
                if (state == TX_INIT)
                begin
                    next_cnt = 10'(cnt + 10'h001);
                    if (cnt == 10'(INIT_CYCLES - 1))
                    begin
                        next_state = TX_RUN;
                        init_done = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= TX_SLEEP;
            cnt <= '0;
            pos <= '0;
            cur <= '0;
            ser_out <= STOP_BIT;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            pos <= next_pos;
            cur <= next_cur;
            ser_out <= next_ser;
        end
    end

    assign ready = (state == TX_RUN);

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    chk_clock_bits_fixed: assert property (load |=> frame_ok(cur))
        else $error("frame clock bits wrong");
    chk_align_sent: assert property (load && align |=> cur[10:1] == ALIGN_WORD)
        else $error("alignment pattern not sent");
    chk_word_framed: assert property (load && !send_align |=> cur[10:1] == $past(word))
        else $error("data word not framed");
    chk_init_length: assert property ($rose(ready) |-> $past(cnt) == 10'(INIT_CYCLES - 1))
        else $error("init length wrong");
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import lsc_pkg::*;
;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic transmit_clock = 1'b0;
    logic receiver_reference_clock = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata, rdata;
    logic avs_waitrequest, irq, ser_out, rx_serial, lock_n, parallel_out_oe, rclk_out, rclk_oe;
    logic [WORD_BITS-1:0] tx_word = 10'h000;
    logic [WORD_BITS-1:0] rx_word = 10'h007;
    logic [WORD_BITS-1:0] parallel_out_word;
    logic align_request_a = 1'b1;
    logic align_request_b = 1'b0;
    logic sleep_n = 1'b1;
    logic out_enable = 1'b1;
    logic use_sync = 1'b0;
    logic corrupt = 1'b0;
    logic frame_tick, held;
    logic [1:0] seen;
    logic [FRAME_BITS-1:0] frame;
    int fail_count = 0;
    int tests_run = 0;

    initial forever #5 mclk = ~mclk;
    initial begin #3; forever #40 transmit_clock = ~transmit_clock; end
    initial begin #17; forever #40 receiver_reference_clock = ~receiver_reference_clock; end

    lsc_serdes #(.INIT_CYCLES(8)) i_dut (.mclk(mclk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .transmit_clock(transmit_clock),
        .tx_word(tx_word), .align_request_a(align_request_a),
        .align_request_b(align_request_b), .sleep_n(sleep_n), .out_enable(out_enable),
        .ser_out(ser_out), .rx_serial(rx_serial),
        .receiver_reference_clock(receiver_reference_clock), .lock_n(lock_n),
        .parallel_out_word(parallel_out_word), .parallel_out_oe(parallel_out_oe),
        .rclk_out(rclk_out), .rclk_oe(rclk_oe));

    // Once use_sync is set, the far side resends alignment frames while the lock status is high.
    lsc_far_tx i_far (.bit_clock(receiver_reference_clock), .align(use_sync & lock_n),
        .corrupt(corrupt), .word(rx_word), .serial(rx_serial), .frame_tick(frame_tick));

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        logic w;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= ~wr;
        avs_write <= wr;
        do
        begin
            // Answers settle mid-cycle and hold up to the next rising edge, which decides.
            @(negedge mclk);
            w = avs_waitrequest;
            rd = avs_readdata;
            @(posedge mclk);
            n++;
        end
        while (w !== 1'b0 && n < 20);
        if (w !== 1'b0)
        begin
            fail_count++;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    function automatic logic [WORD_BITS-1:0] therm_word();
        int n;
        n = $urandom_range(8, 1);
        n = (n >= 5) ? n + 1 : n;
        return 10'((1 << n) - 1);
    endfunction

    function automatic logic [FRAME_BITS-1:0] exp_frame(input logic [WORD_BITS-1:0] w);
        return {STOP_BIT, w, START_BIT};
    endfunction

    // Thermometer words hold one rising edge per frame, so no false clock-bit position exists.
    task automatic wait_lock(input logic therm);
        int n;
        n = 0;
        while (lock_n !== 1'b0 && n < 60)
        begin
            @(posedge frame_tick);
            if (therm)
            begin
                rx_word = therm_word();
            end
            n++;
        end
        if (lock_n !== 1'b0)
        begin
            fail_count++;
        end
    endtask

    task automatic grab_frame(output logic [FRAME_BITS-1:0] f);
        logic prev;
        int n;
        prev = 1'b1;
        n = 0;
        repeat (2 * FRAME_BITS + 1) @(posedge transmit_clock);
        while (!(prev === 1'b0 && ser_out === 1'b1) && n < 40)
        begin
            prev = ser_out;
            @(posedge transmit_clock);
            n++;
        end
        if (!(prev === 1'b0 && ser_out === 1'b1))
        begin
            fail_count++;
        end
        for (int i = 0; i < FRAME_BITS; i++)
        begin
            f[i] = ser_out;
            @(posedge transmit_clock);
        end
    endtask

    task automatic report_and_stop();
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial
    begin
        #400000;
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(81));
        repeat (4) @(posedge mclk);
        chk_bit(lock_n, 1'b1);
        chk_bit(parallel_out_oe, 1'b0);
        chk_bit(rclk_oe, 1'b0);
        resetn <= 1'b1;
        repeat (4) @(posedge transmit_clock);
        bus(1'b0, REG_STATUS, 32'h0, rdata);
        chk_bit(rdata[STAT_TXRDY_BIT], 1'b0);
        repeat (12) @(posedge transmit_clock);
        bus(1'b0, REG_STATUS, 32'h0, rdata);
        chk_bit(rdata[STAT_TXRDY_BIT], 1'b1);
        bus(1'b0, REG_IRQ_STAT, 32'h0, rdata);
        chk_bit(rdata[2], 1'b1);
        bus(1'b1, REG_IRQ_STAT, 32'h4, rdata);
        bus(1'b0, REG_IRQ_STAT, 32'h0, rdata);
        chk_bit(rdata[2], 1'b0);
        bus(1'b0, REG_CTRL, 32'h0, rdata);
        chk_val(rdata, 32'h0);
        bus(1'b1, 5'h14, 32'hFFFFFFFF, rdata);
        bus(1'b0, 5'h14, 32'h0, rdata);
        chk_val(rdata, 32'h0);
        $display("test tx_init done");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            align_request_a <= (i == 0);
            align_request_b <= (i == 1);
            tx_word <= (i == 3) ? 10'h3FF : ((i == 2) ? 10'h000 : 10'($urandom));
            grab_frame(frame);
            chk_val(32'(frame), 32'(exp_frame((i < 2) ? ALIGN_WORD : tx_word)));
        end
        bus(1'b1, REG_CTRL, 32'h1, rdata);
        bus(1'b0, REG_CTRL, 32'h0, rdata);
        chk_val(rdata, 32'h1);
        grab_frame(frame);
        chk_val(32'(frame), 32'(exp_frame(ALIGN_WORD)));
        bus(1'b1, REG_CTRL, 32'h0, rdata);
        $display("test tx_frames done");
        bus(1'b1, REG_IRQ_MASK, 32'h3, rdata);
        bus(1'b0, REG_IRQ_MASK, 32'h0, rdata);
        chk_val(rdata, 32'h3);
        wait_lock(1'b1);
        chk_bit(lock_n, 1'b0);
        chk_bit(parallel_out_oe, 1'b1);
        chk_bit(irq, 1'b1);
        bus(1'b0, REG_STATUS, 32'h0, rdata);
        chk_bit(rdata[STAT_LOCK_BIT], 1'b1);
        seen = 2'b00;
        repeat (FRAME_BITS)
        begin
            @(posedge receiver_reference_clock);
            seen = seen | {rclk_out, !rclk_out};
        end
        chk_val(32'(seen), 32'h3);
        bus(1'b1, REG_IRQ_STAT, 32'h1, rdata);
        @(posedge mclk);
        chk_bit(irq, 1'b0);
        $display("test random_lock done");
        for (int i = 0; i < 8; i++)
        begin
            @(posedge frame_tick);
            rx_word = (i == 0) ? 10'h000 : ((i == 1) ? 10'h3FF : 10'($urandom));
            repeat (3) @(posedge frame_tick);
            chk_val(32'(parallel_out_word), 32'(rx_word));
            bus(1'b0, REG_RX_WORD, 32'h0, rdata);
            chk_val(rdata, 32'(rx_word));
        end
        $display("test rx_words done");
        @(posedge mclk);
        out_enable <= 1'b0;
        repeat (8) @(posedge mclk);
        chk_bit(parallel_out_oe, 1'b0);
        chk_bit(rclk_oe, 1'b0);
        chk_bit(lock_n, 1'b0);
        out_enable <= 1'b1;
        repeat (8) @(posedge mclk);
        chk_bit(parallel_out_oe, 1'b1);
        $display("test out_enable done");
        // Words around the loss are suspect, so none is compared there.
        use_sync = 1'b1;
        held = 1'b0;
        for (int i = 0; i < 12; i++)
        begin
            @(posedge frame_tick);
            corrupt = (i < 3);
            held = held | lock_n;
        end
        chk_bit(held, 1'b0);
        for (int i = 0; i < 7; i++)
        begin
            @(posedge frame_tick);
            corrupt = (i < 4);
        end
        chk_bit(lock_n, 1'b1);
        chk_bit(parallel_out_oe, 1'b0);
        chk_bit(rclk_oe, 1'b0);
        chk_bit(irq, 1'b1);
        bus(1'b0, REG_IRQ_STAT, 32'h0, rdata);
        chk_bit(rdata[1], 1'b1);
        wait_lock(1'b0);
        chk_bit(lock_n, 1'b0);
        chk_val(32'(parallel_out_word), 32'(ALIGN_WORD));
        bus(1'b1, REG_IRQ_STAT, 32'h7, rdata);
        $display("test lock_loss done");
        @(posedge mclk);
        sleep_n <= 1'b0;
        out_enable <= 1'b0;
        repeat (20) @(posedge mclk);
        chk_bit(lock_n, 1'b1);
        chk_bit(parallel_out_oe, 1'b0);
        chk_bit(ser_out, 1'b0);
        sleep_n <= 1'b1;
        out_enable <= 1'b1;
        wait_lock(1'b0);
        chk_bit(lock_n, 1'b0);
        chk_bit(parallel_out_oe, 1'b1);
        $display("test sleep done");
        report_and_stop();
    end
endmodule
`default_nettype wire
